// ===== shared/clk_gate_pkg.sv
// Package with register map, field positions and reset values of the gate block.
`default_nettype none
package clk_gate_pkg;
	localparam int unsigned NUM_PERIPH = 11;
	localparam logic [31:0] GATE0_OFFSET = 32'h0000_0024;
	localparam int unsigned PIN_A_BIT = 0;
	localparam int unsigned PIN_B_BIT = 1;
	localparam int unsigned RSVD_LO_BIT = 2;
	localparam int unsigned RSVD_HI_BIT = 4;
	localparam int unsigned DMA_BIT = 5;
	localparam int unsigned SYNC_A_BIT = 6;
	localparam int unsigned SYNC_B_BIT = 7;
	localparam int unsigned SYNC_C_BIT = 8;
	localparam int unsigned ASYNC_A_BIT = 9;
	localparam int unsigned ASYNC_B_BIT = 10;
	// Reset image of bits 10..0: bit 9 clocked, all others stopped.
	localparam logic [10:0] GATE0_RESET = 11'h5ff;
	// Bits that software may change; reserved 4..2 excluded.
	localparam logic [10:0] GATE0_WMASK = 11'h7e3;
	// Upper bits 31..11 are outside this block and read as this value.
	localparam logic [20:0] GATE0_UPPER_RD = 21'h00_0000;
endpackage
`default_nettype wire

// ===== rtl/periph_access_guard.sv
// Per-peripheral guard that blocks bus selects while that peripheral is gated.
`timescale 1ns/1ps
`default_nettype none
module periph_access_guard #(
	parameter int unsigned N = 11
) (
	// Gate state
	input wire logic [N-1:0] i_clk_off,
	// Upstream selects and answers
	input wire logic [N-1:0] i_psel,
	input wire logic [N-1:0] i_pready,
	// Downstream selects and answers
	output logic [N-1:0] o_psel,
	output logic [N-1:0] o_pready
);
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_lane
			// A gated peripheral never sees the select; the access is
			// answered at once so the bus cannot hang on a stopped clock.
			assign o_psel[g] = i_psel[g] & ~i_clk_off[g]; // [RQ2]
			assign o_pready[g] = i_clk_off[g] ? 1'b1 : i_pready[g]; // [RQ2]
		end
	endgenerate
endmodule // periph_access_guard
`default_nettype wire

// ===== rtl/periph_clock_gate.sv
// Peripheral clock gate register (low half) with APB slave and access guard.
// Overview of operation
// (RQ1) Bit 0 runs clock, 1 stops it.
// (RQ2) Gated peripheral bus accesses are not serviced.
// (RQ3) Gating keeps peripheral register contents intact.
// (RQ4) Bit 9 gates async port A, reset 0.
// (RQ5) Bit 10 gates async port B, reset 1.
// (RQ6) Bits 8,7,6 gate sync ports C,B,A.
// (RQ7) Bit 5 gates DMA, reset 1.
// (RQ8) Bit 1 gates pin port B, reset 1.
// (RQ9) Bit 0 gates pin port A, reset 1.
// (RQ10) Bits 4..2 reserved, read-only, fixed value.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module periph_clock_gate #(
	parameter int unsigned N = 11
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Clock stop controls (high stops) toward each peripheral clock gate cell
	output logic o_async_serial_b_clk_off,
	output logic o_async_serial_a_clk_off,
	output logic o_sync_serial_c_clk_off,
	output logic o_sync_serial_b_clk_off,
	output logic o_sync_serial_a_clk_off,
	output logic o_dma_clk_off,
	output logic o_pin_port_b_clk_off,
	output logic o_pin_port_a_clk_off,
	// Peripheral bus selects, indexed by gate bit
	input wire logic [N-1:0] i_periph_psel,
	input wire logic [N-1:0] i_periph_pready,
	output logic [N-1:0] o_periph_psel,
	output logic [N-1:0] o_periph_pready
);
	// The register image is fixed at eleven lanes, so no other N is served.
	if (N != clk_gate_pkg::NUM_PERIPH) begin : g_bad_n
		$error("periph_clock_gate: N must equal 11");
	end

	logic [10:0] gate_q;
	logic [10:0] gate_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic hit;
	logic wr_go;
	logic rd_go;

	function automatic logic addr_hit(input logic [31:0] a);
		addr_hit = (a[11:2] == clk_gate_pkg::GATE0_OFFSET[11:2]);
	endfunction

	assign hit = addr_hit(i_paddr);
	assign wr_go = i_psel & i_penable & i_pwrite & hit;
	assign rd_go = i_psel & ~i_penable & ~i_pwrite;

	// Only writable bits take new data; reserved bits hold their reset value.
	always_comb begin
		gate_d = gate_q;
		if (wr_go)
			gate_d = (i_pwdata[10:0] & clk_gate_pkg::GATE0_WMASK) |
				(gate_q & ~clk_gate_pkg::GATE0_WMASK); // [RQ10]
	end

	always_comb begin
		rdata_d = rdata_q;
		if (rd_go)
			rdata_d = hit ? {clk_gate_pkg::GATE0_UPPER_RD, gate_q} :
				32'h0000_0000;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			gate_q <= clk_gate_pkg::GATE0_RESET; // [RQ4] [RQ5] [RQ7]
			rdata_q <= 32'h0000_0000;
		end else begin
			gate_q <= gate_d;
			rdata_q <= rdata_d;
		end
	end

	// Zero wait states; read data is captured in the setup cycle.
	assign o_pready = 1'b1;
	assign o_pslverr = 1'b0;
	assign o_prdata = rdata_q;

	// A set bit stops the clock; the peripheral's flops simply hold, so
	// its registers keep their contents while gated.
	assign o_async_serial_b_clk_off =
		gate_q[clk_gate_pkg::ASYNC_B_BIT]; // [RQ1] [RQ3] [RQ5]
	assign o_async_serial_a_clk_off =
		gate_q[clk_gate_pkg::ASYNC_A_BIT]; // [RQ1] [RQ4]
	assign o_sync_serial_c_clk_off =
		gate_q[clk_gate_pkg::SYNC_C_BIT]; // [RQ6]
	assign o_sync_serial_b_clk_off =
		gate_q[clk_gate_pkg::SYNC_B_BIT]; // [RQ6]
	assign o_sync_serial_a_clk_off =
		gate_q[clk_gate_pkg::SYNC_A_BIT]; // [RQ6]
	assign o_dma_clk_off =
		gate_q[clk_gate_pkg::DMA_BIT]; // [RQ7]
	assign o_pin_port_b_clk_off =
		gate_q[clk_gate_pkg::PIN_B_BIT]; // [RQ8]
	assign o_pin_port_a_clk_off =
		gate_q[clk_gate_pkg::PIN_A_BIT]; // [RQ9]

	// Reserved lanes are never gated, so their selects pass unchanged.
	logic [N-1:0] off_vec;
	assign off_vec = gate_q & clk_gate_pkg::GATE0_WMASK;

	periph_access_guard #(
		.N(N)
	) u_guard (
		.i_clk_off(off_vec),
		.i_psel(i_periph_psel),
		.i_pready(i_periph_pready),
		.o_psel(o_periph_psel),
		.o_pready(o_periph_pready)
	); // [RQ2]

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	logic past_valid_q;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			past_valid_q <= 1'b0;
		else
			past_valid_q <= 1'b1;
	end

	// Register and read path checks.
	reset_value_a: assert property ($rose(i_rst_n) |-> // [RQ4]
		gate_q == clk_gate_pkg::GATE0_RESET)
		else $error("gate register reset value wrong");
	reset_outputs_a: assert property ($rose(i_rst_n) |-> // [RQ8] [RQ9]
		o_async_serial_b_clk_off && !o_async_serial_a_clk_off &&
		o_sync_serial_c_clk_off && o_sync_serial_b_clk_off &&
		o_sync_serial_a_clk_off && o_dma_clk_off &&
		o_pin_port_b_clk_off && o_pin_port_a_clk_off &&
		o_prdata == 32'h0000_0000)
		else $error("gate outputs wrong after reset");
	write_takes_a: assert property (wr_go |=> // [RQ1]
		gate_q[10:5] == $past(i_pwdata[10:5]) &&
		gate_q[1:0] == $past(i_pwdata[1:0]))
		else $error("write did not update gate bits");
	reserved_fixed_a: assert property (past_valid_q |-> // [RQ10]
		gate_q[4:2] == clk_gate_pkg::GATE0_RESET[4:2])
		else $error("reserved bits changed");
	no_write_hold_a: assert property (!wr_go |=> $stable(gate_q)) // [RQ3]
		else $error("gate bits changed without a write");
	foreign_write_a: assert property ( // [RQ10]
		i_psel && i_penable && i_pwrite && !hit |=> $stable(gate_q))
		else $error("write to another address changed the gates");
	read_back_a: assert property (rd_go && hit ##1 i_penable |-> // [RQ4]
		o_prdata == {clk_gate_pkg::GATE0_UPPER_RD, $past(gate_q)})
		else $error("read data differs from register");
	unmapped_zero_a: assert property (rd_go && !hit |=> // [RQ10]
		o_prdata == 32'h0000_0000)
		else $error("unmapped read returned data");
	prdata_hold_a: assert property (!rd_go |=> $stable(o_prdata)) // [RQ4]
		else $error("read data moved without a read");

	// Gate outputs and guard checks.
	outputs_map_a: assert property ( // [RQ5]
		o_async_serial_b_clk_off == gate_q[clk_gate_pkg::ASYNC_B_BIT] &&
		o_async_serial_a_clk_off == gate_q[clk_gate_pkg::ASYNC_A_BIT] &&
		o_sync_serial_c_clk_off == gate_q[clk_gate_pkg::SYNC_C_BIT] &&
		o_sync_serial_b_clk_off == gate_q[clk_gate_pkg::SYNC_B_BIT] &&
		o_sync_serial_a_clk_off == gate_q[clk_gate_pkg::SYNC_A_BIT] &&
		o_dma_clk_off == gate_q[clk_gate_pkg::DMA_BIT] &&
		o_pin_port_b_clk_off == gate_q[clk_gate_pkg::PIN_B_BIT] &&
		o_pin_port_a_clk_off == gate_q[clk_gate_pkg::PIN_A_BIT])
		else $error("gate outputs mismatched");
	gated_blocked_a: assert property ( // [RQ2]
		gate_q[clk_gate_pkg::DMA_BIT] |->
		!o_periph_psel[clk_gate_pkg::DMA_BIT] &&
		o_periph_pready[clk_gate_pkg::DMA_BIT])
		else $error("gated DMA select passed through");
	open_passes_a: assert property ( // [RQ1]
		!gate_q[clk_gate_pkg::ASYNC_A_BIT] |->
		o_periph_psel[clk_gate_pkg::ASYNC_A_BIT] ==
		i_periph_psel[clk_gate_pkg::ASYNC_A_BIT])
		else $error("clocked port select blocked");

	// Every lane is checked, so a slip in one guard bit cannot hide.
	genvar k;
	generate
		for (k = 0; k < N; k++) begin : g_lane_chk
			lane_gated_a: assert property (@(posedge i_sys_clk) // [RQ2]
				disable iff (!i_rst_n)
				off_vec[k] |-> !o_periph_psel[k] && o_periph_pready[k])
				else $error("gated lane was not blocked");
			lane_open_a: assert property (@(posedge i_sys_clk) // [RQ1]
				disable iff (!i_rst_n) !off_vec[k] |->
				o_periph_psel[k] == i_periph_psel[k] &&
				o_periph_pready[k] == i_periph_pready[k])
				else $error("clocked lane did not pass");
		end
	endgenerate

	cov_write_c: cover property (wr_go);
	cov_read_c: cover property (rd_go && hit);
	cov_ungate_c: cover property ($fell(o_dma_clk_off));
	cov_blocked_c: cover property (gate_q[clk_gate_pkg::DMA_BIT] &&
		i_periph_psel[clk_gate_pkg::DMA_BIT]);
	cov_all_off_c: cover property (gate_q == 11'h7ff);
endmodule // periph_clock_gate
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the peripheral clock gate register and its guard.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic i_sys_clk, i_rst_n, psel, penable, pwrite;
	logic [31:0] paddr, pwdata, rd;
	logic [10:0] ps_in, pr_in;
	int mismatches, tests_run;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, ab, aa, sc, sb, sa, dm, pb, pa;
	wire logic [10:0] ps_out, pr_out;
	wire logic [10:0] gate = {ab, aa, sc, sb, sa, dm, 3'h0, pb, pa};
	periph_clock_gate #(.N(11)) DUT (.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_async_serial_b_clk_off(ab), .o_async_serial_a_clk_off(aa),
		.o_sync_serial_c_clk_off(sc), .o_sync_serial_b_clk_off(sb),
		.o_sync_serial_a_clk_off(sa), .o_dma_clk_off(dm),
		.o_pin_port_b_clk_off(pb), .o_pin_port_a_clk_off(pa),
		.i_periph_psel(ps_in), .i_periph_pready(pr_in),
		.o_periph_psel(ps_out), .o_periph_pready(pr_out));
	initial begin
		i_sys_clk = 1'b0;
		forever #2 i_sys_clk = ~i_sys_clk;
	end
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge i_sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_sys_clk);
		penable <= 1'b1;
		do @(posedge i_sys_clk); while (pready !== 1'b1);
		rd = prdata;
		check("pslverr", {31'h0, pslverr}, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Reads the register, then compares gate levels and the access guard.
	task automatic expect_reg(input logic [10:0] v);
		apb(1'b0, clk_gate_pkg::GATE0_OFFSET, 32'h0);
		check("register", rd, {21'h0, v});
		@(posedge i_sys_clk);
		#1;
		check("gates", {21'h0, gate}, {21'h0, v & 11'h7e3});
		check("guard sel", {21'h0, ps_out},
			{21'h0, ps_in & ~(v & 11'h7e3)});
		check("guard rdy", {21'h0, pr_out},
			{21'h0, v & 11'h7e3 | pr_in});
	endtask
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#20000;
		mismatches++;
		stop_test();
	end
	initial begin
		i_rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		ps_in = 11'h7ff;
		pr_in = 11'h0a5;
		mismatches = 0;
		tests_run = 0;
		repeat (8) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		expect_reg(11'h5ff);
		apb(1'b1, clk_gate_pkg::GATE0_OFFSET, 32'h0);
		expect_reg(11'h01c);
		// Walking one across every lane, reserved lanes included.
		for (int i = 0; i < 11; i++) begin
			apb(1'b1, clk_gate_pkg::GATE0_OFFSET, 32'h1 << i);
			expect_reg(11'h01c | (11'h1 << i) & 11'h7e3);
		end
		apb(1'b1, clk_gate_pkg::GATE0_OFFSET, 32'hffff_ffff);
		expect_reg(11'h7ff);
		apb(1'b1, 32'h0000_0028, 32'h0);
		apb(1'b0, 32'h0000_0028, 32'h0);
		check("unmapped", rd, 32'h0);
		pr_in <= 11'h35a;
		ps_in <= 11'h2d6;
		expect_reg(11'h7ff);
		apb(1'b1, clk_gate_pkg::GATE0_OFFSET, 32'h0000_0200);
		expect_reg(11'h21c);
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
